// [hdl/msf_framer.sv]
// Our own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "msf_map.svh"

module msf_framer
    import msf_pkg::*;
(
    input  wire logic          core_clk_in,
    input  wire logic          rstn_in,
    input  wire msf_bus_req_t  bus_in,
    output logic         [7:0] rdata_out,
    input  wire msf_rx_byte_t  rx_in,
    output logic               rx_ready_out,
    output logic               irq_out
);
    logic [7:0]                    framing_character;
    logic [7:0]                    receive_string_length;
    logic [7:0]                    control;
    logic [7:0]                    buf_index;
    logic [7:0]                    msg_len;
    logic [7:0]                    count;
    logic                          rx_ready;
    logic [`MSF_NUM_EVENTS-1:0]    irq_status;
    logic [`MSF_NUM_EVENTS-1:0]    irq_mask;
    logic [`MSF_NUM_EVENTS-1:0]    events;
    msf_state_t                    state;
    logic                          cfg_wr;
    logic                          active;
    logic                          term_mode;
    logic                          is_frame_char;
    logic                          msg_done;
    logic                          overflow;
    logic                          store_we;
    logic [7:0]                    store_rd_data;

    // Address match for a write strobe.
    function automatic logic hit(input logic [11:0] addr, input logic [11:0] off);
        return addr == off;
    endfunction

    // Any change of framing setup restarts the framer so a half message never mixes modes.
    assign cfg_wr = bus_in.wr && (hit(bus_in.addr, `MSF_OFF_FRAMING_CHAR) ||
                                  hit(bus_in.addr, `MSF_OFF_STRING_LEN));
    assign active = control[`MSF_BIT_CTRL_ENABLE] && !cfg_wr;
    assign term_mode = (receive_string_length == 8'h00);
    assign is_frame_char = (rx_in.data == framing_character);

    // Byte classification for the current cycle.
    always_comb begin
        msg_done = 1'b0;
        overflow = 1'b0;
        store_we = 1'b0;
        if (active && rx_in.valid && (state == MSF_ST_COLLECT)) begin
            if (term_mode) begin
                if (is_frame_char) begin
                    msg_done = 1'b1;
                end else if (count == `MSF_BUF_DEPTH) begin
                    overflow = 1'b1;
                end else begin
                    store_we = 1'b1;
                end
            end else begin
                store_we = 1'b1;
                msg_done = ((count + 8'h01) == receive_string_length);
            end
        end
    end

    // Configuration registers steer the framer.
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            framing_character     <= `MSF_RST_FRAMING_CHAR;
            receive_string_length <= `MSF_RST_STRING_LEN;
            control               <= `MSF_RST_CONTROL;
            buf_index             <= 8'h00;
            irq_mask              <= `MSF_RST_IRQ_MASK;
        end else if (bus_in.wr) begin
            if (hit(bus_in.addr, `MSF_OFF_FRAMING_CHAR)) begin
                framing_character <= bus_in.wdata;
            end
            if (hit(bus_in.addr, `MSF_OFF_STRING_LEN)) begin
                receive_string_length <= bus_in.wdata;
            end
            if (hit(bus_in.addr, `MSF_OFF_CONTROL)) begin
                control <= bus_in.wdata;
            end
            if (hit(bus_in.addr, `MSF_OFF_BUF_INDEX)) begin
                buf_index <= bus_in.wdata;
            end
            if (hit(bus_in.addr, `MSF_OFF_IRQ_MASK)) begin
                irq_mask <= bus_in.wdata[`MSF_NUM_EVENTS-1:0];
            end
        end
    end

    // Framing state and byte count.
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state <= MSF_ST_IDLE;
            count <= 8'h00;
        end else if (!active) begin
            state <= MSF_ST_IDLE;
            count <= 8'h00;
        end else begin
            unique case (state)
                MSF_ST_IDLE: begin
                    state <= term_mode ? MSF_ST_COLLECT : MSF_ST_HUNT;
                    count <= 8'h00;
                end
                MSF_ST_HUNT: begin
                    if (rx_in.valid && is_frame_char) begin
                        state <= MSF_ST_COLLECT;
                    end
                    count <= 8'h00;
                end
                MSF_ST_COLLECT: begin
                    if (msg_done || overflow) begin
                        state <= term_mode ? MSF_ST_COLLECT : MSF_ST_HUNT;
                        count <= 8'h00;
                    end else if (store_we) begin
                        count <= count + 8'h01;
                    end
                end
                default: begin
                    state <= MSF_ST_IDLE;
                    count <= 8'h00;
                end
            endcase
        end
    end

    // Length of the last completed message, stored alongside the ready flag.
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            msg_len <= 8'h00;
        end else if (msg_done) begin
            msg_len <= term_mode ? count : receive_string_length;
        end
    end

    // Ready flag; a new message wins over a clear in the same cycle.
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rx_ready <= 1'b0;
        end else begin
            rx_ready <= msg_done || (rx_ready && !(bus_in.wr &&
                        hit(bus_in.addr, `MSF_OFF_RX_FLAGS) && bus_in.wdata[`MSF_BIT_RX_READY]));
        end
    end

    assign events[`MSF_BIT_IRQ_DONE]     = msg_done;
    assign events[`MSF_BIT_IRQ_OVERFLOW] = overflow;

    // Sticky interrupt status, write one to clear; set beats clear.
    genvar gi;
    generate
        for (gi = 0; gi < `MSF_NUM_EVENTS; gi = gi + 1) begin : g_irq
            always_ff @(posedge core_clk_in or negedge rstn_in) begin
                if (!rstn_in) begin
                    irq_status[gi] <= 1'b0;
                end else begin
                    irq_status[gi] <= events[gi] || (irq_status[gi] && !(bus_in.wr &&
                                      hit(bus_in.addr, `MSF_OFF_IRQ_STATUS) && bus_in.wdata[gi]));
                end
            end
        end
    endgenerate

    assign irq_out      = |(irq_status & irq_mask);
    assign rx_ready_out = rx_ready;

    // Read data stand for exactly the cycle after the strobe; unmapped reads give zero.
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rdata_out <= 8'h00;
        end else if (!bus_in.rd) begin
            rdata_out <= 8'h00;
        end else begin
            unique case (bus_in.addr)
                `MSF_OFF_FRAMING_CHAR: rdata_out <= framing_character;
                `MSF_OFF_STRING_LEN:   rdata_out <= receive_string_length;
                `MSF_OFF_RX_FLAGS:     rdata_out <= {7'h00, rx_ready};
                `MSF_OFF_IRQ_STATUS:   rdata_out <= {6'h00, irq_status};
                `MSF_OFF_IRQ_MASK:     rdata_out <= {6'h00, irq_mask};
                `MSF_OFF_CONTROL:      rdata_out <= control;
                `MSF_OFF_BUF_INDEX:    rdata_out <= buf_index;
                `MSF_OFF_BUF_DATA:     rdata_out <= store_rd_data;
                `MSF_OFF_MSG_LEN:      rdata_out <= msg_len;
                default:               rdata_out <= 8'h00;
            endcase
        end
    end

    msf_msg_store i_msf_msg_store (
        .core_clk_in (core_clk_in),
        .wr_en_in    (store_we),
        .wr_idx_in   (count),
        .wr_data_in  (rx_in.data),
        .rd_idx_in   (buf_index),
        .rd_data_out (store_rd_data)
    );

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rstn_in);

    a_char_reg_write: assert property (
        bus_in.wr && hit(bus_in.addr, `MSF_OFF_FRAMING_CHAR)
        |=> framing_character == $past(bus_in.wdata))
        else $error("Framing character not stored.");

    a_len_reg_write: assert property (
        bus_in.wr && hit(bus_in.addr, `MSF_OFF_STRING_LEN)
        |=> receive_string_length == $past(bus_in.wdata) && state == MSF_ST_IDLE)
        else $error("Length not stored or framer not restarted.");

    a_term_ends_msg: assert property (
        active && state == MSF_ST_COLLECT && term_mode && rx_in.valid && is_frame_char
        |=> rx_ready && msg_len == $past(count) && count == 8'h00)
        else $error("Terminator did not end the message.");

    a_start_found: assert property (
        active && state == MSF_ST_HUNT && rx_in.valid && is_frame_char
        |=> state == MSF_ST_COLLECT && count == 8'h00)
        else $error("Start character not recognised.");

    a_exact_count: assert property (
        active && state == MSF_ST_COLLECT && !term_mode && rx_in.valid &&
        (count + 8'h01) == receive_string_length
        |=> rx_ready && state == MSF_ST_HUNT && msg_len == receive_string_length)
        else $error("Start-mode message did not end at the set length.");

    a_hunt_discard: assert property (
        active && state == MSF_ST_HUNT && !(rx_in.valid && is_frame_char)
        |=> state == MSF_ST_HUNT && count == 8'h00 && !$past(store_we))
        else $error("Byte before start character was kept.");

    a_ready_sticky: assert property (
        rx_ready && !(bus_in.wr && hit(bus_in.addr, `MSF_OFF_RX_FLAGS))
        |=> rx_ready [*1])
        else $error("Ready flag dropped without a clear.");

    a_ready_cause: assert property (
        $rose(rx_ready) |-> $past(msg_done) && $past(state) == MSF_ST_COLLECT)
        else $error("Ready flag rose without a completed message.");
endmodule
`default_nettype wire

// [hdl/msf_map.svh]
`ifndef MSF_MAP_SVH
`define MSF_MAP_SVH

// Register offsets on the plain register port.
`define MSF_OFF_FRAMING_CHAR  12'h321
`define MSF_OFF_STRING_LEN    12'h322
`define MSF_OFF_RX_FLAGS      12'h327
`define MSF_OFF_IRQ_STATUS    12'h3F0
`define MSF_OFF_IRQ_MASK      12'h3F1
`define MSF_OFF_CONTROL       12'h3F2
`define MSF_OFF_BUF_INDEX     12'h3F3
`define MSF_OFF_BUF_DATA      12'h3F4
`define MSF_OFF_MSG_LEN       12'h3F5

// Field positions.
`define MSF_BIT_RX_READY      0
`define MSF_BIT_IRQ_DONE      0
`define MSF_BIT_IRQ_OVERFLOW  1
`define MSF_BIT_CTRL_ENABLE   0

// Reset values.
`define MSF_RST_FRAMING_CHAR  8'h00
`define MSF_RST_STRING_LEN    8'h00
`define MSF_RST_CONTROL       8'h01
`define MSF_RST_IRQ_MASK      2'h0

// Message store depth in bytes; also the longest terminated message.
`define MSF_BUF_DEPTH         8'hFF
`define MSF_NUM_EVENTS        2

`endif

// [hdl/msf_pkg.sv]
`default_nettype none

package msf_pkg;

    // Framing state, one-hot.
    typedef enum logic [2:0] {
        MSF_ST_IDLE    = 3'b001,
        MSF_ST_HUNT    = 3'b010,
        MSF_ST_COLLECT = 3'b100
    } msf_state_t;

    // One request on the plain register port.
    typedef struct packed {
        logic [11:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } msf_bus_req_t;

    // One received byte from the serial receiver.
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } msf_rx_byte_t;

endpackage

`default_nettype wire

// [hdl/msf_msg_store.sv]
`timescale 1ns/1ps
`default_nettype none
`include "msf_map.svh"

module msf_msg_store (
    input  wire logic       core_clk_in,
    input  wire logic       wr_en_in,
    input  wire logic [7:0] wr_idx_in,
    input  wire logic [7:0] wr_data_in,
    input  wire logic [7:0] rd_idx_in,
    output logic      [7:0] rd_data_out
);
    // Storage is plain flip-flops with no reset; software reads only after a message completes.
    logic [7:0] mem [0:254];

    // Write one received byte at its position in the message.
    always_ff @(posedge core_clk_in) begin
        if (wr_en_in && (wr_idx_in < `MSF_BUF_DEPTH)) begin
            mem[wr_idx_in] <= wr_data_in;
        end
    end

    // Out-of-range indices read as zero rather than wrapping.
    always_comb begin
        rd_data_out = (rd_idx_in < `MSF_BUF_DEPTH) ? mem[rd_idx_in] : 8'h00;
    end
endmodule
`default_nettype wire

// [sim/msf_rx_src.sv]
`timescale 1ns/1ps
`default_nettype none

// Remote serial sender that hands received bytes to the framer.
module msf_rx_src
    import msf_pkg::*;
(
    input  wire logic          core_clk_in,
    output var  msf_rx_byte_t  rx_out
);

    // The line starts quiet; data is meaningless while valid is low.
    initial begin
        rx_out = '0;
    end

    // Sends bytes back to back, one per cycle, the fastest rate allowed.
    // Between bursts the data lines show the inverse of the last byte so a
    // design that samples without valid picks up a wrong value.
    task automatic send(input logic [7:0] q[$]);
        foreach (q[i]) begin
            @(posedge core_clk_in);
            rx_out <= '{valid: 1'b1, data: q[i]};
        end
        @(posedge core_clk_in);
        rx_out <= '{valid: 1'b0, data: ~q[q.size()-1]};
    endtask

endmodule
`default_nettype wire

// [sim/master_serial_receive_framer_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "msf_map.svh"

module master_serial_receive_framer_tb
    import msf_pkg::*;
();
    logic         core_clk_in;
    logic         rstn_in;
    msf_bus_req_t bus;
    logic [7:0]   rdata;
    msf_rx_byte_t rx;
    logic         rx_ready;
    logic         irq;
    int           bad_count;
    int           n_checks;
    int           cycles;

    msf_framer i_msf_framer (
        .core_clk_in  (core_clk_in),
        .rstn_in      (rstn_in),
        .bus_in       (bus),
        .rdata_out    (rdata),
        .rx_in        (rx),
        .rx_ready_out (rx_ready),
        .irq_out      (irq)
    );

    msf_rx_src i_msf_rx_src (
        .core_clk_in (core_clk_in),
        .rx_out      (rx)
    );

    // Free-running 100 MHz clock.
    initial begin
        core_clk_in = 1'b0;
        forever #5 core_clk_in = ~core_clk_in;
    end

    // Cuts a hang short; the tests need well under a thousand cycles.
    always @(posedge core_clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            bad_count++;
            close_out();
        end
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
        @(posedge core_clk_in);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk_in);
        bus.wr <= 1'b0;
        #1;
    endtask

    // Read data is taken in the one cycle after the strobe, where it stands.
    task automatic rd_chk(input string what, input logic [11:0] a, input logic [7:0] exp);
        @(posedge core_clk_in);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk_in);
        bus.rd <= 1'b0;
        #1;
        chk8(what, exp, rdata);
    endtask

    task automatic rd_store(input logic [7:0] idx, input logic [7:0] exp);
        wr_reg(`MSF_OFF_BUF_INDEX, idx);
        rd_chk("store byte", `MSF_OFF_BUF_DATA, exp);
    endtask

    task automatic wait_ready();
        for (int i = 0; i < 20 && rx_ready !== 1'b1; i++) @(posedge core_clk_in);
        #1;
    endtask

    task automatic t_reset();
        chk8("ready out", 8'h00, {7'h00, rx_ready});
        chk8("irq out", 8'h00, {7'h00, irq});
        rd_chk("framing char", `MSF_OFF_FRAMING_CHAR, 8'h00);
        rd_chk("length", `MSF_OFF_STRING_LEN, 8'h00);
        rd_chk("control", `MSF_OFF_CONTROL, 8'h01);
        rd_chk("mask", `MSF_OFF_IRQ_MASK, 8'h00);
        rd_chk("flags", `MSF_OFF_RX_FLAGS, 8'h00);
        rd_chk("unmapped", 12'h000, 8'h00);
        rd_chk("status", `MSF_OFF_IRQ_STATUS, 8'h00);
        rd_chk("index", `MSF_OFF_BUF_INDEX, 8'h00);
        rd_chk("msg length", `MSF_OFF_MSG_LEN, 8'h00);
        wr_reg(`MSF_OFF_FRAMING_CHAR, 8'hA5);
        rd_chk("framing char", `MSF_OFF_FRAMING_CHAR, 8'hA5);
        wr_reg(`MSF_OFF_STRING_LEN, 8'h5A);
        rd_chk("length", `MSF_OFF_STRING_LEN, 8'h5A);
        $display("test reset done");
    endtask

    task automatic t_term();
        wr_reg(`MSF_OFF_FRAMING_CHAR, 8'h0D);
        wr_reg(`MSF_OFF_STRING_LEN, 8'h00);
        i_msf_rx_src.send({8'h41, 8'h42});
        repeat (3) @(posedge core_clk_in);
        #1;
        chk8("ready early", 8'h00, {7'h00, rx_ready});
        i_msf_rx_src.send({8'h0D});
        wait_ready();
        chk8("ready out", 8'h01, {7'h00, rx_ready});
        rd_chk("flags", `MSF_OFF_RX_FLAGS, 8'h01);
        rd_chk("msg length", `MSF_OFF_MSG_LEN, 8'h02);
        rd_store(8'h00, 8'h41);
        rd_store(8'h01, 8'h42);
        rd_chk("status", `MSF_OFF_IRQ_STATUS, 8'h01);
        chk8("irq masked", 8'h00, {7'h00, irq});
        wr_reg(`MSF_OFF_IRQ_MASK, 8'h01);
        chk8("irq unmasked", 8'h01, {7'h00, irq});
        wr_reg(`MSF_OFF_IRQ_STATUS, 8'h01);
        chk8("irq cleared", 8'h00, {7'h00, irq});
        wr_reg(`MSF_OFF_RX_FLAGS, 8'h01);
        rd_chk("flags cleared", `MSF_OFF_RX_FLAGS, 8'h00);
        $display("test terminator done");
    endtask

    // Junk before the start byte, and a start-valued byte inside the data.
    task automatic t_start();
        wr_reg(`MSF_OFF_FRAMING_CHAR, 8'hAA);
        wr_reg(`MSF_OFF_STRING_LEN, 8'h03);
        i_msf_rx_src.send({8'h11, 8'h22, 8'hAA, 8'hAA, 8'h05});
        repeat (3) @(posedge core_clk_in);
        #1;
        chk8("ready early", 8'h00, {7'h00, rx_ready});
        i_msf_rx_src.send({8'h06});
        wait_ready();
        chk8("ready out", 8'h01, {7'h00, rx_ready});
        chk8("irq out", 8'h01, {7'h00, irq});
        rd_chk("msg length", `MSF_OFF_MSG_LEN, 8'h03);
        rd_store(8'h00, 8'hAA);
        rd_store(8'h01, 8'h05);
        rd_store(8'h02, 8'h06);
        wr_reg(`MSF_OFF_IRQ_STATUS, 8'h01);
        wr_reg(`MSF_OFF_RX_FLAGS, 8'h01);
        chk8("ready cleared", 8'h00, {7'h00, rx_ready});
        $display("test start done");
    endtask

    // A terminated run that never sees its terminator must overflow, not complete.
    task automatic t_overflow();
        logic [7:0] q[$];
        for (int i = 0; i < 256; i++) begin
            q.push_back(8'h55);
        end
        wr_reg(`MSF_OFF_FRAMING_CHAR, 8'h0D);
        wr_reg(`MSF_OFF_STRING_LEN, 8'h00);
        i_msf_rx_src.send(q);
        repeat (2) @(posedge core_clk_in);
        #1;
        chk8("ready on overflow", 8'h00, {7'h00, rx_ready});
        rd_chk("status", `MSF_OFF_IRQ_STATUS, 8'h02);
        chk8("irq masked", 8'h00, {7'h00, irq});
        rd_chk("msg length", `MSF_OFF_MSG_LEN, 8'h03);
        rd_store(8'h00, 8'h55);
        rd_store(8'hFE, 8'h55);
        wr_reg(`MSF_OFF_IRQ_STATUS, 8'h02);
        wr_reg(`MSF_OFF_CONTROL, 8'h00);
        i_msf_rx_src.send({8'h41, 8'h0D});
        repeat (3) @(posedge core_clk_in);
        #1;
        chk8("ready disabled", 8'h00, {7'h00, rx_ready});
        rd_chk("status disabled", `MSF_OFF_IRQ_STATUS, 8'h00);
        wr_reg(`MSF_OFF_CONTROL, 8'h01);
        $display("test overflow done");
    endtask

    // Main sequence: reset for three cycles, then the scenarios in turn.
    initial begin
        bus = '0;
        rstn_in = 1'b0;
        cycles = 0;
        bad_count = 0;
        n_checks = 0;
        repeat (3) @(posedge core_clk_in);
        rstn_in <= 1'b1;
        @(posedge core_clk_in);
        #1;
        t_reset();
        t_term();
        t_start();
        t_overflow();
        close_out();
    end

endmodule
`default_nettype wire
